/* File: core/storage_port_consts.vh */
/*
  Constants for the storage port control and maintenance registers:
  register addresses, field positions, command values, port state codes
  and timing figures.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef STORAGE_PORT_CONSTS_VH
`define STORAGE_PORT_CONSTS_VH

// ==========================================================
// Register addresses (longword I/O space)
`define ADDR_SOFT_CHIP_RESET          32'h2000_4030
`define ADDR_SHARED_HEADER_ADDRESS    32'h2000_4044
`define ADDR_PORT_ENABLE_COMMAND      32'h2000_409C
`define ADDR_PORT_DISABLE_COMMAND     32'h2000_40A0
`define ADDR_PORT_INITIALIZE_COMMAND  32'h2000_40A4
`define ADDR_TIMER_RESTART_COMMAND    32'h2000_40A8
`define ADDR_TIMER_FORCE_EXPIRY_CMD   32'h2000_40AC
`define ADDR_MAINT_CONTROL_STATUS     32'h2000_40B0

// ==========================================================
// Write values
`define CMD_GO_VALUE                  32'h0000_0001
`define CHIP_RESET_KEY                32'hFFFF_FFFF

// ==========================================================
// Maintenance control/status fields
`define MCS_MAINT_INIT_BIT            0
`define MCS_TIMER_DISABLE_BIT         1
`define MCS_INTERRUPT_ENABLE_BIT      2
`define MCS_SIMPLIFIED_MODE_BIT       3
`define MCS_HOST_ACCESS_FEATURE_BIT   4
`define MCS_CTRL_RESET                4'h0

// ==========================================================
// Port status word flag positions
`define PSW_DISABLE_COMPLETE_BIT      2
`define PSW_TIMER_EXPIRED_BIT         6

// ==========================================================
// Port states; bit 0 marks the maintenance variant
`define ST_UNINIT                     3'h0
`define ST_UNINIT_MAINT               3'h1
`define ST_DISABLED                   3'h2
`define ST_DISABLED_MAINT             3'h3
`define ST_ENABLED                    3'h4
`define ST_ENABLED_MAINT              3'h5

// ==========================================================
// Timing
`define CLK_HZ                        10000000
`define TIMER_TIMEOUT_S               7'h64
`define TICK_CYCLES_PER_S             24'h98_9680
`define INIT_CYCLES                   4'h8
`define MAINT_INIT_CYCLES             4'h4

`endif

/* File: core/maint_timer.v */
/*
  Maintenance watchdog timer: a one-second tick divider and a seconds
  down counter that flags expiry once per load.
  Assumes a single clock and a synchronous active-low reset that already
  includes the software chip reset.
*/
`timescale 1ns/1ns
`include "storage_port_consts.vh"

module maint_timer #(
  parameter [23:0] TICK_CYCLES = `TICK_CYCLES_PER_S,
  parameter [6:0]  TIMEOUT_S   = `TIMER_TIMEOUT_S
) (
  input  wire mclk_i,
  input  wire rst_n_i,
  input  wire start_i,
  input  wire restart_i,
  input  wire hold_i,
  input  wire stop_i,
  output wire running_o,
  output reg  expire_o
);

  reg         active_q;
  reg  [23:0] pre_q;
  reg  [6:0]  sec_q;
  wire        tick;

  // ==========================================================
  // Divider enable and countdown
  assign tick      = (pre_q == TICK_CYCLES - 24'h00_0001);
  assign running_o = active_q & ~hold_i;

  // Hold reloads every cycle so release starts a fresh full period
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      active_q <= 1'b0;
      pre_q    <= 24'h00_0000;
      sec_q    <= 7'h00;
      expire_o <= 1'b0;
    end
    else
    begin
      expire_o <= 1'b0;
      if (stop_i)
      begin
        active_q <= 1'b0;
        pre_q    <= 24'h00_0000;
        sec_q    <= TIMEOUT_S;
      end
      else if (start_i)
      begin
        active_q <= 1'b1;
        pre_q    <= 24'h00_0000;
        sec_q    <= TIMEOUT_S;
      end
      else if (hold_i)
      begin
        pre_q <= 24'h00_0000;
        sec_q <= TIMEOUT_S;
      end
      else if (restart_i && active_q)
      begin
        pre_q <= 24'h00_0000;
        sec_q <= TIMEOUT_S;
      end
      else if (active_q)
      begin
        if (tick)
        begin
          pre_q <= 24'h00_0000;
          if (sec_q <= 7'h01)
          begin
            active_q <= 1'b0;
            expire_o <= 1'b1;
          end
          else
          begin
            sec_q <= sec_q - 7'h01;
          end
        end
        else
        begin
          pre_q <= pre_q + 24'h00_0001;
        end
      end
    end
  end

endmodule

/* File: core/storage_port_control_regs.v */
/*
  Port control and maintenance registers of a storage host adapter:
  command registers, port state machine, maintenance control/status,
  software chip reset and the shared header address register.
  Assumes longword register accesses synchronous to mclk_i, one access
  per cycle, and an outside status block that releases the flags.
*/
`timescale 1ns/1ns
`include "storage_port_consts.vh"

module storage_port_control_regs #(
  parameter [23:0] TICK_CYCLES = `TICK_CYCLES_PER_S
) (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire [31:0] reg_addr_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [31:0] reg_wdata_i,
  output reg  [31:0] reg_rdata_o,
  output reg         reg_rvalid_o,
  input  wire        status_release_i,
  output wire        disable_complete_flag_o,
  output wire        timer_expired_flag_o,
  output wire        int_req_o,
  output wire [2:0]  port_state_o,
  output wire        init_busy_o,
  output wire        timer_running_o,
  output wire        host_access_feature_bit_o,
  output wire        simplified_mode_bit_o,
  output wire [31:0] shared_header_address_o
);

  // ==========================================================
  // Declarations
  reg         soft_reset_q;
  wire        rst_n_int;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         init_busy_q;
  reg         init_busy_d;
  reg  [3:0]  init_cnt_q;
  reg  [3:0]  init_cnt_d;
  reg         min_busy_q;
  reg  [3:0]  min_cnt_q;
  reg  [3:0]  ctrl_q;
  reg         pdc_q;
  reg         mte_q;
  reg  [31:0] header_addr_q;
  wire        is_go;
  wire        wr_enable;
  wire        wr_disable;
  wire        wr_init;
  wire        wr_restart;
  wire        wr_force;
  wire        wr_mcs;
  wire        wr_header;
  wire        wr_chip_reset;
  wire        min_start;
  wire        min_done;
  wire        init_done;
  wire        timer_expire;
  wire        timer_running;
  wire        expiry_event;
  reg         pdc_set;
  reg         timer_start;
  reg  [31:0] rdata_d;

  // ==========================================================
  // Software chip reset
  // One-cycle internal pulse folded into the synchronous reset; it only
  // answers to the pin reset, so it cannot hold itself in reset.
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      soft_reset_q <= 1'b0;
    end
    else
    begin
      soft_reset_q <= wr_chip_reset;
    end
  end

  assign rst_n_int = rst_n_i & ~soft_reset_q;

  // ==========================================================
  // Write decode
  // Only the value one starts a command; anything else is dropped
  assign is_go         = (reg_wdata_i == `CMD_GO_VALUE);
  assign wr_enable     = reg_wr_i && is_go && (reg_addr_i == `ADDR_PORT_ENABLE_COMMAND);
  assign wr_disable    = reg_wr_i && is_go && (reg_addr_i == `ADDR_PORT_DISABLE_COMMAND);
  assign wr_init       = reg_wr_i && is_go && (reg_addr_i == `ADDR_PORT_INITIALIZE_COMMAND);
  assign wr_restart    = reg_wr_i && is_go && (reg_addr_i == `ADDR_TIMER_RESTART_COMMAND);
  assign wr_force      = reg_wr_i && is_go && (reg_addr_i == `ADDR_TIMER_FORCE_EXPIRY_CMD);
  assign wr_mcs        = reg_wr_i && (reg_addr_i == `ADDR_MAINT_CONTROL_STATUS);
  assign wr_header     = reg_wr_i && (reg_addr_i == `ADDR_SHARED_HEADER_ADDRESS);
  assign wr_chip_reset = reg_wr_i && (reg_addr_i == `ADDR_SOFT_CHIP_RESET) &&
                         (reg_wdata_i == `CHIP_RESET_KEY);

  // Maintenance init starts on a written one; a zero does nothing
  assign min_start = wr_mcs && reg_wdata_i[`MCS_MAINT_INIT_BIT] && !min_busy_q;
  assign min_done  = min_busy_q && (min_cnt_q == `MAINT_INIT_CYCLES - 4'h1);
  assign init_done = init_busy_q && (init_cnt_q == `INIT_CYCLES - 4'h1);

  // Force-expiry behaves as a real expiry so software sees one path
  assign expiry_event = timer_expire | wr_force;

  // ==========================================================
  // Maintenance control/status register
  always @(posedge mclk_i)
  begin
    if (!rst_n_int)
    begin
      ctrl_q <= `MCS_CTRL_RESET;
    end
    else if (wr_mcs)
    begin
      ctrl_q <= reg_wdata_i[4:1];
    end
  end

  // Maintenance init sequencer; the bit reads one while it runs
  always @(posedge mclk_i)
  begin
    if (!rst_n_int)
    begin
      min_busy_q <= 1'b0;
      min_cnt_q  <= 4'h0;
    end
    else if (min_start)
    begin
      min_busy_q <= 1'b1;
      min_cnt_q  <= 4'h0;
    end
    else if (min_done)
    begin
      min_busy_q <= 1'b0;
      min_cnt_q  <= 4'h0;
    end
    else if (min_busy_q)
    begin
      min_cnt_q <= min_cnt_q + 4'h1;
    end
  end

  // ==========================================================
  // Port state machine
  // Priority: maintenance init, then expiry, then init completion, then
  // host commands. Maintenance variant bit survives enable/disable/init.
  always @*
  begin
    state_d     = state_q;
    init_busy_d = init_busy_q;
    init_cnt_d  = init_cnt_q;
    pdc_set     = 1'b0;
    timer_start = 1'b0;
    if (min_busy_q || min_start)
    begin
      state_d     = `ST_UNINIT;
      init_busy_d = 1'b0;
      init_cnt_d  = 4'h0;
    end
    else if (expiry_event)
    begin
      state_d     = `ST_UNINIT_MAINT;
      init_busy_d = 1'b0;
      init_cnt_d  = 4'h0;
    end
    else if (init_done)
    begin
      state_d     = {2'b01, state_q[0]};
      init_busy_d = 1'b0;
      init_cnt_d  = 4'h0;
      pdc_set     = 1'b1;
      timer_start = 1'b1;
    end
    else if (init_busy_q)
    begin
      init_cnt_d = init_cnt_q + 4'h1;
    end
    else if (wr_init)
    begin
      init_busy_d = 1'b1;
      init_cnt_d  = 4'h0;
    end
    else
    begin
      case (state_q)
        `ST_DISABLED, `ST_DISABLED_MAINT:
        begin
          if (wr_enable)
          begin
            state_d = {2'b10, state_q[0]};
          end
        end
        `ST_ENABLED, `ST_ENABLED_MAINT:
        begin
          if (wr_disable)
          begin
            state_d = {2'b01, state_q[0]};
            pdc_set = 1'b1;
          end
        end
        default:
        begin
          state_d = state_q;
        end
      endcase
    end
  end

  always @(posedge mclk_i)
  begin
    if (!rst_n_int)
    begin
      state_q     <= `ST_UNINIT;
      init_busy_q <= 1'b0;
      init_cnt_q  <= 4'h0;
    end
    else
    begin
      state_q     <= state_d;
      init_busy_q <= init_busy_d;
      init_cnt_q  <= init_cnt_d;
    end
  end

  // ==========================================================
  // Status flags
  // Set beats release so an event in the release cycle is kept
  always @(posedge mclk_i)
  begin
    if (!rst_n_int)
    begin
      pdc_q <= 1'b0;
      mte_q <= 1'b0;
    end
    else if (min_busy_q || min_start)
    begin
      pdc_q <= 1'b0;
      mte_q <= 1'b0;
    end
    else
    begin
      if (pdc_set)
      begin
        pdc_q <= 1'b1;
      end
      else if (status_release_i)
      begin
        pdc_q <= 1'b0;
      end
      if (expiry_event)
      begin
        mte_q <= 1'b1;
      end
      else if (status_release_i)
      begin
        mte_q <= 1'b0;
      end
    end
  end

  assign int_req_o = ctrl_q[`MCS_INTERRUPT_ENABLE_BIT - 1] & (pdc_q | mte_q);

  // ==========================================================
  // Shared header address
  // Not touched by maintenance init; only the pin reset or the software chip reset clears it
  always @(posedge mclk_i)
  begin
    if (!rst_n_int)
    begin
      header_addr_q <= 32'h0000_0000;
    end
    else if (wr_header && (state_q == `ST_UNINIT) && !init_busy_q)
    begin
      header_addr_q <= reg_wdata_i;
    end
  end

  // ==========================================================
  // Maintenance timer
  maint_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .TIMEOUT_S   (`TIMER_TIMEOUT_S)
  ) u_timer (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_int),
    .start_i   (timer_start),
    .restart_i (wr_restart),
    .hold_i    (ctrl_q[`MCS_TIMER_DISABLE_BIT - 1]),
    .stop_i    (min_busy_q | min_start | wr_force),
    .running_o (timer_running),
    .expire_o  (timer_expire)
  );

  // ==========================================================
  // Read path
  // Write-only registers and unmapped addresses read as zero
  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (reg_addr_i == `ADDR_MAINT_CONTROL_STATUS)
    begin
      rdata_d = {27'h000_0000, ctrl_q, min_busy_q};
    end
    else if (reg_addr_i == `ADDR_SHARED_HEADER_ADDRESS)
    begin
      rdata_d = header_addr_q;
    end
    else
    begin
      rdata_d = 32'h0000_0000;
    end
  end

  always @(posedge mclk_i)
  begin
    if (!rst_n_int)
    begin
      reg_rdata_o  <= 32'h0000_0000;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign disable_complete_flag_o   = pdc_q;
  assign timer_expired_flag_o      = mte_q;
  assign port_state_o              = state_q;
  assign init_busy_o               = init_busy_q;
  assign timer_running_o           = timer_running;
  assign host_access_feature_bit_o = ctrl_q[`MCS_HOST_ACCESS_FEATURE_BIT - 1];
  assign simplified_mode_bit_o     = ctrl_q[`MCS_SIMPLIFIED_MODE_BIT - 1];
  assign shared_header_address_o   = header_addr_q;

endmodule

/* File: testbench/storage_port_monitor.sv */
/* Port checker for storage_port_control_regs.
   Assumes it is bound to the top module: one clock, sync active-low reset. */
`timescale 1ns/1ns
`include "storage_port_consts.vh"

module storage_port_monitor (
  input wire        mclk_i,
  input wire        rst_n_i,
  input wire [31:0] reg_addr_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_wdata_i,
  input wire [31:0] reg_rdata_o,
  input wire        reg_rvalid_o,
  input wire        status_release_i,
  input wire        disable_complete_flag_o,
  input wire        timer_expired_flag_o,
  input wire        int_req_o,
  input wire [2:0]  port_state_o,
  input wire        init_busy_o,
  input wire        timer_running_o,
  input wire        host_access_feature_bit_o,
  input wire        simplified_mode_bit_o,
  input wire [31:0] shared_header_address_o
);
  // ==========================================================
  // Decoded writes; only the value one starts a command
  wire go       = reg_wr_i && (reg_wdata_i == `CMD_GO_VALUE);
  wire go_dis   = go && (reg_addr_i == `ADDR_PORT_DISABLE_COMMAND);
  wire go_init  = go && (reg_addr_i == `ADDR_PORT_INITIALIZE_COMMAND);
  wire go_frc   = go && (reg_addr_i == `ADDR_TIMER_FORCE_EXPIRY_CMD);
  wire en_wr    = reg_wr_i && (reg_addr_i == `ADDR_PORT_ENABLE_COMMAND);
  wire hdr_wr   = reg_wr_i && (reg_addr_i == `ADDR_SHARED_HEADER_ADDRESS);
  wire chip_rst = reg_wr_i && (reg_addr_i == `ADDR_SOFT_CHIP_RESET)
                  && (reg_wdata_i == `CHIP_RESET_KEY);
  wire in_dis   = port_state_o inside {`ST_DISABLED, `ST_DISABLED_MAINT};
  wire in_en    = port_state_o inside {`ST_ENABLED, `ST_ENABLED_MAINT};

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Assertions; busy windows are excluded where init may move the state
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe got no answer");
  a_enable_guard: assert property (
    en_wr && in_dis && go && !init_busy_o |=> port_state_o == $past(port_state_o) + 3'h2)
    else $error("enable from disabled not taken");
  a_enable_ignored: assert property (
    en_wr && !(go && in_dis) && !init_busy_o |=> $stable(port_state_o))
    else $error("enable write moved the state");
  a_disable_done: assert property (go_dis && in_en && !init_busy_o |=>
    port_state_o == $past(port_state_o) - 3'h2 && disable_complete_flag_o)
    else $error("disable did not complete");
  a_disable_ignored: assert property (
    go_dis && !in_en && !init_busy_o |=> $stable(port_state_o))
    else $error("disable write moved the state");
  a_init_span: assert property (go_init && !init_busy_o |=>
    init_busy_o [*8] ##1 (!init_busy_o && disable_complete_flag_o))
    else $error("init span or completion flag wrong");
  a_force_expiry: assert property (go_frc |=>
    port_state_o == `ST_UNINIT_MAINT && timer_expired_flag_o)
    else $error("force expiry had no effect");
  a_header_write: assert property (
    hdr_wr && port_state_o == `ST_UNINIT && !init_busy_o
    |=> shared_header_address_o == $past(reg_wdata_i))
    else $error("header write not stored");
  a_header_keep: assert property (!$stable(shared_header_address_o)
    |-> $past(hdr_wr) || $past(chip_rst, 2))
    else $error("header changed without cause");
  a_control_read: assert property (
    reg_rd_i && reg_addr_i == `ADDR_MAINT_CONTROL_STATUS |=> reg_rdata_o[31:3]
    == {27'h0, host_access_feature_bit_o, simplified_mode_bit_o})
    else $error("control read shows wrong upper bits");

  // ==========================================================
  // Main scenarios reached
  c_enable: cover property (en_wr && go && in_dis);
  c_init: cover property (go_init ##9 !init_busy_o);
  c_expiry: cover property ($rose(timer_expired_flag_o) && int_req_o);
endmodule

/* File: testbench/host_cpu_model.sv */
/* Host processor model issuing longword register writes and reads.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ns
`include "storage_port_consts.vh"

module host_cpu_model (
  input  wire        mclk_i,
  input  wire [2:0]  port_state_i,
  input  wire        timer_running_i,
  output reg  [31:0] reg_addr_o,
  output reg         reg_wr_o,
  output reg         reg_rd_o,
  output reg  [31:0] reg_wdata_o
);
  // ==========================================================
  // Idle bus at time zero
  initial
  begin
    reg_addr_o = 32'h0000_0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 32'h0000_0000;
  end

  // One access held over exactly one taken edge; released lines invert
  // so that stale values never look valid
  task acc(input bit wr, input logic [31:0] a, input logic [31:0] d, input int g);
    begin
      repeat (g + 1) @(posedge mclk_i);
      #1;
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = wr;
      reg_rd_o = !wr;
      @(posedge mclk_i);
      #1;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = ~reg_addr_o;
      reg_wdata_o = ~reg_wdata_o;
    end
  endtask

  // ==========================================================
  // Host-side duties
  task cmd(input logic [31:0] a, input int g);
    acc(1'b1, a, `CMD_GO_VALUE, g);
  endtask

  task force_expiry(input int g);
    if (timer_running_i && port_state_i >= `ST_DISABLED)
      cmd(`ADDR_TIMER_FORCE_EXPIRY_CMD, g);
  endtask

  task chip_reset();
    acc(1'b1, `ADDR_SOFT_CHIP_RESET, `CHIP_RESET_KEY, 0);
  endtask

  // Octaword-aligned, and only while uninitialized
  task set_header(input logic [31:0] d, input int g);
    if (port_state_i == `ST_UNINIT)
      acc(1'b1, `ADDR_SHARED_HEADER_ADDRESS, d & 32'hffff_fff0, g);
  endtask

  // Reserved and diagnostic bits are always written as zero
  task set_mcs(input logic [2:0] d, input int g);
    acc(1'b1, `ADDR_MAINT_CONTROL_STATUS, {29'h0, d}, g);
  endtask
endmodule

/* File: testbench/storage_port_control_regs_tb_top.sv */
/* Self-checking bench for storage_port_control_regs with a host model.
   Assumes a one-second tick cut to 4 cycles, so expiry takes 400. */
`timescale 1ns/1ns
`include "storage_port_consts.vh"

module storage_port_control_regs_tb_top;
  reg         mclk_i;
  reg         rst_n_i;
  reg         status_release_i = 1'b0;
  wire [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o, shared_header_address_o;
  wire [2:0]  port_state_o;
  wire        reg_wr_i, reg_rd_i, reg_rvalid_o, int_req_o, init_busy_o;
  wire        disable_complete_flag_o, timer_expired_flag_o, timer_running_o;
  wire        host_access_feature_bit_o, simplified_mode_bit_o;
  integer     err_total = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     n;
  logic [31:0] seed = 32'h0000_ae3d;
  logic [31:0] hdr;
  logic [31:0] exp_q[$];

  // ==========================================================
  // Design, host model and clock
  storage_port_control_regs #(.TICK_CYCLES(24'h00_0004)) i_storage_port_control_regs (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .status_release_i(status_release_i),
    .disable_complete_flag_o(disable_complete_flag_o), .int_req_o(int_req_o),
    .timer_expired_flag_o(timer_expired_flag_o), .port_state_o(port_state_o),
    .init_busy_o(init_busy_o), .timer_running_o(timer_running_o),
    .host_access_feature_bit_o(host_access_feature_bit_o),
    .simplified_mode_bit_o(simplified_mode_bit_o),
    .shared_header_address_o(shared_header_address_o));
  host_cpu_model i_host_cpu_model (
    .mclk_i(mclk_i), .port_state_i(port_state_o), .timer_running_i(timer_running_o),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_wdata_o(reg_wdata_i));
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // ==========================================================
  // Helpers
  function automatic int nxt_gap();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[1:0];
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count = check_count + 1;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total = err_total + 1;
    end
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e, input int g);
    exp_q.push_back(e);
    i_host_cpu_model.acc(1'b0, a, 32'h0000_0000, g);
  endtask
  task cmd(input logic [31:0] a, input logic [2:0] st);
    i_host_cpu_model.cmd(a, nxt_gap());
    chk("state", st, port_state_o);
  endtask
  task pulse_release();
    @(posedge mclk_i);
    #1 status_release_i = 1'b1;
    @(posedge mclk_i);
    #1 status_release_i = 1'b0;
  endtask
  // Bounded wait on a level, counting cycles
  task wait_on(input bit expiry);
    n = 0;
    while ((expiry ? timer_expired_flag_o !== 1'b1 : init_busy_o === 1'b1) && n < 600)
    begin
      @(posedge mclk_i);
      #1 n = n + 1;
    end
    if (expiry)
      chk("expiry span", 400, (n >= 396 && n <= 402) ? 400 : n);
  endtask
  task do_init(input logic [2:0] st);
    i_host_cpu_model.cmd(`ADDR_PORT_INITIALIZE_COMMAND, nxt_gap());
    wait_on(1'b0);
    chk("init cycles", 8, n);
    chk("state", st, port_state_o);
    chk("disable complete", 1, disable_complete_flag_o);
    chk("timer running", 1, timer_running_o);
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Read answers matched in order against noted values; cycle ceiling
  always @(negedge mclk_i)
    if (reg_rvalid_o === 1'b1)
      chk("read data", exp_q.pop_front(), reg_rdata_o);
  always @(posedge mclk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      err_total = err_total + 1;
      print_verdict();
    end
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    rst_n_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    rd(`ADDR_MAINT_CONTROL_STATUS, 32'h0000_0000, nxt_gap());
    rd(`ADDR_PORT_ENABLE_COMMAND, 32'h0000_0000, nxt_gap());
    rd(32'h2000_40B4, 32'h0000_0000, nxt_gap());
    cmd(`ADDR_PORT_ENABLE_COMMAND, `ST_UNINIT);
    cmd(`ADDR_PORT_DISABLE_COMMAND, `ST_UNINIT);
    hdr = seed & 32'hffff_fff0;
    i_host_cpu_model.set_header(hdr, nxt_gap());
    rd(`ADDR_SHARED_HEADER_ADDRESS, hdr, nxt_gap());
    $display("test uninitialized done");
    do_init(`ST_DISABLED);
    chk("interrupt", 0, int_req_o);
    i_host_cpu_model.acc(1'b1, `ADDR_PORT_ENABLE_COMMAND, 32'h0000_0002, nxt_gap());
    chk("state", `ST_DISABLED, port_state_o);
    cmd(`ADDR_PORT_ENABLE_COMMAND, `ST_ENABLED);
    cmd(`ADDR_PORT_ENABLE_COMMAND, `ST_ENABLED);
    cmd(`ADDR_PORT_DISABLE_COMMAND, `ST_DISABLED);
    chk("disable complete", 1, disable_complete_flag_o);
    cmd(`ADDR_PORT_DISABLE_COMMAND, `ST_DISABLED);
    i_host_cpu_model.set_mcs(3'h4, nxt_gap());
    chk("interrupt", 1, int_req_o);
    rd(`ADDR_MAINT_CONTROL_STATUS, 32'h0000_0004, nxt_gap());
    pulse_release();
    chk("interrupt", 0, int_req_o);
    $display("test commands done");
    repeat (300) @(posedge mclk_i);
    i_host_cpu_model.cmd(`ADDR_TIMER_RESTART_COMMAND, 0);
    wait_on(1'b1);
    chk("state", `ST_UNINIT_MAINT, port_state_o);
    chk("interrupt", 1, int_req_o);
    $display("test expiry done");
    do_init(`ST_DISABLED_MAINT);
    pulse_release();
    i_host_cpu_model.set_mcs(3'h6, nxt_gap());
    chk("timer running", 0, timer_running_o);
    i_host_cpu_model.cmd(`ADDR_TIMER_RESTART_COMMAND, 0);
    repeat (450) @(posedge mclk_i);
    #1 chk("timer expired", 0, timer_expired_flag_o);
    i_host_cpu_model.set_mcs(3'h4, 0);
    wait_on(1'b1);
    $display("test timer disable done");
    do_init(`ST_DISABLED_MAINT);
    pulse_release();
    i_host_cpu_model.force_expiry(nxt_gap());
    chk("state", `ST_UNINIT_MAINT, port_state_o);
    chk("interrupt", 1, int_req_o);
    i_host_cpu_model.set_mcs(3'h5, 0);
    rd(`ADDR_MAINT_CONTROL_STATUS, 32'h0000_0005, 0);
    repeat (4) @(posedge mclk_i);
    #1 chk("state", `ST_UNINIT, port_state_o);
    chk("timer expired", 0, timer_expired_flag_o);
    chk("header", hdr, shared_header_address_o);
    rd(`ADDR_MAINT_CONTROL_STATUS, 32'h0000_0004, nxt_gap());
    $display("test force and maintenance init done");
    i_host_cpu_model.chip_reset();
    repeat (2) @(posedge mclk_i);
    #1 chk("header", 0, shared_header_address_o);
    rd(`ADDR_MAINT_CONTROL_STATUS, 32'h0000_0000, nxt_gap());
    repeat (3) @(posedge mclk_i);
    chk("pending reads", 0, exp_q.size());
    $display("test chip reset done");
    print_verdict();
  end
endmodule

bind storage_port_control_regs storage_port_monitor i_storage_port_monitor (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .status_release_i(status_release_i),
  .disable_complete_flag_o(disable_complete_flag_o), .int_req_o(int_req_o),
  .timer_expired_flag_o(timer_expired_flag_o), .port_state_o(port_state_o),
  .init_busy_o(init_busy_o), .timer_running_o(timer_running_o),
  .host_access_feature_bit_o(host_access_feature_bit_o),
  .simplified_mode_bit_o(simplified_mode_bit_o),
  .shared_header_address_o(shared_header_address_o));
